// ==== rtl/irq_priority_pkg.sv ====
`default_nettype none
package irq_priority_pkg;
  localparam int NUM_SRC = 9;
  localparam int LVL_W = 3;
  localparam int VEC_W = 7;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  // Register offsets.
  localparam logic [15:0] EXT_LEVEL_SETUP_3_OFS = 16'h430c;
  localparam logic [15:0] TIMER_LEVEL_SETUP_A_OFS = 16'h430e;
  localparam logic [15:0] TIMER_LEVEL_SETUP_B_OFS = 16'h4310;
  localparam logic [15:0] SERIAL_REMOTE_LEVEL_SETUP_OFS = 16'h4312;
  localparam logic [15:0] BUS_SERIAL_LEVEL_SETUP_OFS = 16'h4314;
  localparam logic [15:0] EVENT_STATUS_OFS = 16'h4320;
  localparam logic [15:0] EVENT_MASK_OFS = 16'h4322;
  // Field positions inside each level register.
  localparam int LVL_LO_POS = 0;
  localparam int LVL_HI_POS = 8;
  // Reset values.
  localparam logic [2:0] LVL_RESET = 3'h0;
  localparam logic [1:0] EVT_RESET = 2'h0;
  // Event bit positions.
  localparam int EVT_PREEMPT = 0;
  localparam int EVT_ACCEPT = 1;
  // Vector number of source 0; the others follow in index order.
  localparam logic [6:0] VEC_BASE = 7'h04;
  // Source indices.
  localparam int SRC_DISPLAY = 0;
  localparam int SRC_FIRST_INTERNAL = 1;
  typedef struct packed {
    logic valid;
    logic [6:0] vector;
    logic [2:0] level;
  } irq_req_t;
endpackage : irq_priority_pkg
`default_nettype wire

// ==== rtl/irq_priority_unit.sv ====
// Behaviour
// R1: Every source has a 3-bit level field, readable and writable, reset to 0.
// R2: Among pending enabled causes, only the one of largest level is sent.
// R3: Among equal highest levels, the lowest vector number is sent.
// R4: Unselected causes stay pending and are sent in turn after acceptance.
// R5: A higher cause arriving during a request replaces vector and level.
// R6: The core refuses requests whose level is below its own threshold.
// R7: Timer level register A holds wide timer 0 in 10:8, byte timer in 2:0.
// R8: Timer level register B holds wide timer 2 in 10:8, timer 1 in 2:0.
// R9: Register C holds remote control level in 10:8, async serial in 2:0.
// R10: Register D holds two-wire level in 10:8, sync serial level in 2:0.
// R11: The display level sits in bits 2:0 of its external register, reset 0.
// R12: Software clears the source flag before re-enabling interrupts.
// R13: Software sets every external trigger mode bit to level mode.
// R14: Handlers clear level sources at the peripheral's own flag.
// R15: Unassigned bits of level registers ignore writes and read as zero.
// R16: A newly written level takes part in arbitration from the next cycle.
//
// Implementation choice: strobed register access.
`default_nettype none
module irq_priority_unit #(
  parameter int NUM_SRC = irq_priority_pkg::NUM_SRC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [NUM_SRC-1:0] src_enable,
  input wire logic [NUM_SRC-1:0] src_flag,
  input wire logic core_ack,
  output logic core_req,
  output logic [6:0] core_vector,
  output logic [2:0] core_level,
  output logic irq_out
);
  typedef logic [2:0] lvl_t;

  lvl_t lvl_reg [NUM_SRC];
  logic [NUM_SRC-1:0] taken_reg;
  logic [NUM_SRC-1:0] elig;
  logic [NUM_SRC-1:0] ack_hit;
  irq_priority_pkg::irq_req_t req_reg;
  irq_priority_pkg::irq_req_t req_next;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [1:0] evt;
  logic [1:0] status_next;
  logic [15:0] rdata_reg;
  logic irq_reg;
  int unsigned best_idx;
  lvl_t best_lvl;

  // Source index of the low field of an internal level register, or -1.
  function automatic int lo_src(input logic [15:0] a);
    case (a)
      irq_priority_pkg::TIMER_LEVEL_SETUP_A_OFS: lo_src = 1;
      irq_priority_pkg::TIMER_LEVEL_SETUP_B_OFS: lo_src = 3;
      irq_priority_pkg::SERIAL_REMOTE_LEVEL_SETUP_OFS: lo_src = 5;
      irq_priority_pkg::BUS_SERIAL_LEVEL_SETUP_OFS: lo_src = 7;
      default: lo_src = -1;
    endcase
  endfunction

  // Read value of a level register with unassigned bits as zero.
  function automatic logic [15:0] lvl_word(input lvl_t hi, input lvl_t lo);
    lvl_word = {5'h0, hi, 5'h0, lo}; // R15
  endfunction

  // Level registers; only the 3-bit fields store, the rest is dropped.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NUM_SRC; i++)
      begin
        lvl_reg[i] <= irq_priority_pkg::LVL_RESET; // R1
      end
    end
    else if (reg_wr)
    begin
      if (reg_addr == irq_priority_pkg::EXT_LEVEL_SETUP_3_OFS)
      begin
        lvl_reg[irq_priority_pkg::SRC_DISPLAY] <= reg_wdata[2:0]; // R11
      end
      else if (lo_src(reg_addr) >= 0)
      begin
        lvl_reg[lo_src(reg_addr)] <= reg_wdata[2:0]; // R7 R8 R9 R10
        lvl_reg[lo_src(reg_addr) + 1] <= reg_wdata[10:8]; // R7 R8 R9 R10
      end
    end
  end

  // Marks the cause that the core accepts in this cycle.
  always_comb
  begin
    ack_hit = '0;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (core_ack && req_reg.valid &&
          req_reg.vector == irq_priority_pkg::VEC_BASE + 7'(i))
      begin
        ack_hit[i] = 1'b1; // R4
      end
    end
  end

  // Eligible causes: flagged, enabled, not taken and not being accepted.
  // Dropping the accepted cause at once keeps it from being offered twice.
  assign elig = src_flag & src_enable & ~taken_reg & ~ack_hit;

  // Highest level wins; a >= compare scanning down from the top index keeps the lowest index on ties.
  always_comb
  begin
    best_idx = 0;
    best_lvl = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (elig[i] && (lvl_reg[i] >= best_lvl || !elig[best_idx])) // R2 R3
      begin
        best_idx = i;
        best_lvl = lvl_reg[i];
      end
    end
  end

  // Next request is re-evaluated every cycle, so newer causes that win arbitration preempt.
  always_comb
  begin
    req_next.valid = |elig; // R4
    req_next.vector = irq_priority_pkg::VEC_BASE + 7'(best_idx); // R3
    req_next.level = best_lvl; // R2
  end

  // Registered request toward the core.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      req_reg <= '0;
    end
    else
    begin
      req_reg <= req_next; // R5 R16
    end
  end

  // A cause accepted by the core is held out until its flag falls.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      taken_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_SRC; i++)
      begin
        if (!src_flag[i])
        begin
          taken_reg[i] <= 1'b0; // R4
        end
        else if (ack_hit[i])
        begin
          taken_reg[i] <= 1'b1; // R4
        end
      end
    end
  end

  // Events: preemption of a standing request and acceptance by the core.
  assign evt[irq_priority_pkg::EVT_PREEMPT] = req_reg.valid &&
    req_next.valid && req_next.vector != req_reg.vector &&
    !(core_ack);
  assign evt[irq_priority_pkg::EVT_ACCEPT] = core_ack && req_reg.valid;

  // Sticky status, write one to clear; a new event wins over the clear.
  always_comb
  begin
    status_next = status_reg;
    if (reg_wr && reg_addr == irq_priority_pkg::EVENT_STATUS_OFS)
    begin
      status_next = status_next & ~reg_wdata[1:0];
    end
    status_next = status_next | evt;
  end

  // Status, mask and interrupt output.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      status_reg <= irq_priority_pkg::EVT_RESET;
      mask_reg <= irq_priority_pkg::EVT_RESET;
      irq_reg <= 1'b0;
    end
    else
    begin
      status_reg <= status_next;
      if (reg_wr && reg_addr == irq_priority_pkg::EVENT_MASK_OFS)
      begin
        mask_reg <= reg_wdata[1:0];
        irq_reg <= |(status_next & reg_wdata[1:0]);
      end
      else
      begin
        irq_reg <= |(status_next & mask_reg);
      end
    end
  end

  // Read data stand for one cycle after the strobe, zero otherwise.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || !reg_rd)
    begin
      rdata_reg <= 16'h0000;
    end
    else if (reg_addr == irq_priority_pkg::EXT_LEVEL_SETUP_3_OFS)
    begin
      rdata_reg <= lvl_word(3'h0, lvl_reg[irq_priority_pkg::SRC_DISPLAY]);
    end
    else if (lo_src(reg_addr) >= 0)
    begin
      rdata_reg <= lvl_word(lvl_reg[lo_src(reg_addr) + 1],
                            lvl_reg[lo_src(reg_addr)]); // R15
    end
    else if (reg_addr == irq_priority_pkg::EVENT_STATUS_OFS)
    begin
      rdata_reg <= {14'h0000, status_reg};
    end
    else if (reg_addr == irq_priority_pkg::EVENT_MASK_OFS)
    begin
      rdata_reg <= {14'h0000, mask_reg};
    end
    else
    begin
      rdata_reg <= 16'h0000;
    end
  end

  // Outputs come straight from flip-flops.
  assign reg_rdata = rdata_reg;
  assign core_req = req_reg.valid;
  assign core_vector = req_reg.vector;
  assign core_level = req_reg.level;
  assign irq_out = irq_reg;

  // Checks on the arbitration and register behaviour.
  a_reset_levels: assert property (@(posedge clk_sys) // R1
    !rst_b |=> lvl_reg[0] == 3'h0 && lvl_reg[NUM_SRC-1] == 3'h0)
    else $error("Level not cleared by reset.");

  for (genvar g = 0; g < NUM_SRC; g++)
  begin : g_chk
    a_level_wins: assert property (@(posedge clk_sys) disable iff (!rst_b)
      elig[g] |=> core_req && core_level >= $past(lvl_reg[g])) // R2
      else $error("A higher level cause was passed over.");
    a_tie_lowest: assert property (@(posedge clk_sys) disable iff (!rst_b)
      elig[g] && lvl_reg[g] == best_lvl |=>
        core_vector <= irq_priority_pkg::VEC_BASE + 7'(g)) // R3
      else $error("Tie not resolved to lowest vector.");
  end

  a_pending_kept: assert property (@(posedge clk_sys) disable iff (!rst_b)
    core_ack && core_req && $countones(elig) > 1 ##1 (|elig) |=>
      core_req) // R4
    else $error("Pending cause lost after acceptance.");

  a_no_repeat: assert property (@(posedge clk_sys) disable iff (!rst_b) // R4
    core_ack && core_req |=> !core_req || core_vector != $past(core_vector))
    else $error("Accepted cause offered again.");

  a_preempt_swap: assert property (@(posedge clk_sys) disable iff (!rst_b)
    core_req && elig != 0 && best_lvl > core_level |=>
      core_level == $past(best_lvl) &&
      core_vector == irq_priority_pkg::VEC_BASE + 7'($past(best_idx))) // R5
    else $error("Higher cause did not replace the request.");

  a_layout_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && reg_addr == irq_priority_pkg::TIMER_LEVEL_SETUP_A_OFS |=>
      reg_rdata[10:8] == $past(lvl_reg[2]) &&
      reg_rdata[2:0] == $past(lvl_reg[1])) // R7
    else $error("Timer level register A layout wrong.");

  a_layout_d: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && reg_addr == irq_priority_pkg::BUS_SERIAL_LEVEL_SETUP_OFS |=>
      reg_rdata[10:8] == $past(lvl_reg[8]) &&
      reg_rdata[2:0] == $past(lvl_reg[7])) // R10
    else $error("Bus serial level register layout wrong.");

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_rd && lo_src(reg_addr) >= 0 |=>
      reg_rdata[15:11] == 5'h00 && reg_rdata[7:3] == 5'h00) // R15
    else $error("Reserved level bits read nonzero.");

  a_write_visible: assert property (@(posedge clk_sys) disable iff (!rst_b)
    reg_wr && reg_addr == irq_priority_pkg::EXT_LEVEL_SETUP_3_OFS |=>
      lvl_reg[0] == $past(reg_wdata[2:0])) // R11 R16
    else $error("Display level write not taken.");

  a_event_wins: assert property (@(posedge clk_sys) disable iff (!rst_b)
    evt[1] && reg_wr && reg_addr == irq_priority_pkg::EVENT_STATUS_OFS |=>
      status_reg[1])
    else $error("Event lost to a same-cycle clear.");

  c_single_req: cover property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(core_req) ##[1:4] core_ack);
  c_preempt: cover property (@(posedge clk_sys) disable iff (!rst_b)
    evt[0]);
  c_two_in_turn: cover property (@(posedge clk_sys) disable iff (!rst_b)
    core_ack ##1 core_req ##[1:4] core_ack);
endmodule // irq_priority_unit
`default_nettype wire

// ==== testbench/core_model.sv ====
`default_nettype none
// Behavioural core that takes requests from the priority unit.
module core_model (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic core_req,
  input wire logic [2:0] core_level,
  input wire logic [2:0] core_level_threshold,
  input wire logic [3:0] ack_delay,
  output logic core_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_reg;
  // Counts request cycles so that the core can answer slowly.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b || !core_req || core_ack)
      wait_reg <= 4'h0;
    else
      wait_reg <= wait_reg + 4'h1;
  end
  // Accepts once per request and refuses levels below the threshold.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      core_ack <= 1'b0;
    else
      core_ack <= core_req && !core_ack && wait_reg >= ack_delay &&
        core_level >= core_level_threshold;
  end
endmodule // core_model
`default_nettype wire

// ==== testbench/irq_priority_unit_bench.sv ====
`default_nettype none
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("ERROR at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module irq_priority_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst_b, reg_wr, reg_rd, core_ack, core_req, irq_out;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic [8:0] src_enable, src_flag;
  logic [6:0] core_vector;
  logic [2:0] core_level, threshold;
  logic [3:0] ack_delay;
  int error_cnt = 0;
  int compares = 0;
  logic [15:0] lvl_addr [5] = '{16'h430c, 16'h430e, 16'h4310, 16'h4312,
    16'h4314};
  logic [15:0] lvl_mask [5] = '{16'h0007, 16'h0707, 16'h0707, 16'h0707,
    16'h0707};
  irq_priority_unit i_irq_priority_unit (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_enable(src_enable),
    .src_flag(src_flag), .core_ack(core_ack), .core_req(core_req),
    .core_vector(core_vector), .core_level(core_level), .irq_out(irq_out));
  core_model i_core_model (.clk_sys(clk_sys), .rst_b(rst_b),
    .core_req(core_req), .core_level(core_level),
    .core_level_threshold(threshold), .ack_delay(ack_delay),
    .core_ack(core_ack));
  // Prints the counts and the verdict, then ends the run.
  task finish_test;
    $display("Compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // One-cycle register write.
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // One-cycle register read, compared in the cycle after the strobe.
  task rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, exp)
  endtask
  // Lets two edges pass so registered outputs follow the inputs.
  task settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  // Waits for an accept, checks its vector, then clears that source flag.
  task take(input logic [6:0] vec);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (core_ack !== 1'b1 && n < 50);
    `CHK(core_ack, 1'b1)
    `CHK(core_vector, vec)
    @(posedge clk_sys);
    src_flag[int'(vec - irq_priority_pkg::VEC_BASE)] <= 1'b0;
  endtask
  // Free-running system clock.
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Cuts a hung run short.
  initial
  begin
    #20000;
    error_cnt++;
    finish_test();
  end
  // Main test sequence.
  initial
  begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    src_enable = 9'h000;
    src_flag = 9'h000;
    threshold = 3'h7;
    ack_delay = 4'h3;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rd(lvl_addr[i], 16'h0000);
      wr(lvl_addr[i], 16'hffff);
      rd(lvl_addr[i], lvl_mask[i]);
    end
    wr(16'h4316, 16'hffff);
    rd(16'h4316, 16'h0000);
    wr(16'h430c, 16'h1011);
    wr(16'h430e, 16'h0503);
    wr(16'h4310, 16'h0205);
    wr(16'h4314, 16'h0607);
    @(posedge clk_sys);
    src_enable <= 9'h1bf;
    src_flag <= 9'h00b;
    settle();
    `CHK({core_req, core_vector, core_level}, {1'b1, 7'h07, 3'h5})
    src_flag[2] <= 1'b1;
    settle();
    `CHK({core_vector, core_level}, {7'h06, 3'h5})
    src_flag[8] <= 1'b1;
    src_flag[6] <= 1'b1;
    settle();
    `CHK({core_vector, core_level}, {7'h0c, 3'h6})
    `CHK(core_ack, 1'b0)
    rd(16'h4320, 16'h0001);
    wr(16'h4322, 16'h0001);
    settle();
    `CHK(irq_out, 1'b1)
    wr(16'h4320, 16'h0001);
    settle();
    `CHK(irq_out, 1'b0)
    wr(16'h4314, 16'h0007);
    settle();
    `CHK({core_vector, core_level}, {7'h06, 3'h5})
    wr(16'h4322, 16'h0002);
    rd(16'h4322, 16'h0002);
    threshold <= 3'h0;
    take(7'h06);
    take(7'h07);
    ack_delay <= 4'h0;
    take(7'h05);
    take(7'h04);
    take(7'h0c);
    settle();
    `CHK({core_req, irq_out}, 2'h1)
    finish_test();
  end
endmodule // irq_priority_unit_bench
`default_nettype wire
